/* hw/crtc_regs.vh */
/*
  crtc_regs.vh: register indices, field positions, reset values
  and fixed constants for the row-scan / cursor / start-address block.
  assumes: included by bare name from the design files under hw/.
*/
`ifndef CRTC_REGS_VH
`define CRTC_REGS_VH

// =====================================================================
// controller indices (byte address is four times the index)
`define IDX_PRESET_ROW 8'h08
`define IDX_CELL_HEIGHT 8'h09
`define IDX_CURSOR_START 8'h0a
`define IDX_CURSOR_END 8'h0b
`define IDX_START_HIGH 8'h0c
`define IDX_START_LOW 8'h0d
`define IDX_START_ID 8'h1f
`define IDX_CONTROL 8'h20
`define IDX_STATUS 8'h21

// =====================================================================
// field positions
`define PRESET_LSB 0
`define PRESET_MSB 4
`define BYTE_PAN_LSB 5
`define BYTE_PAN_MSB 6
`define HEIGHT_LSB 0
`define HEIGHT_MSB 4
`define VBS_BIT9 5
`define LC_BIT9 6
`define SCAN_DOUBLE_BIT 7
`define CURSOR_DISABLE_BIT 5
`define SKEW_LSB 5
`define SKEW_MSB 6
`define CTRL_WP_BIT 4
`define CTRL_PAN_COMPAT_BIT 5

// =====================================================================
// reset values and fixed constants
`define RST_REG8 8'h00
`define ROW_MAX 5'h1f
`define PAN_BYTE_PIXELS 8

`endif

/* hw/cursor_shaper.v */
/*
  cursor_shaper.v: decides whether the text cursor is lit on the current
  row scan and applies the character skew delay.
  assumes: one char_en pulse per character clock; row_scan stable per line.
*/
module cursor_shaper (
  input wire clk,
  input wire rst_n,
  input wire char_en,
  input wire [4:0] row_scan,
  input wire [4:0] cell_height,
  input wire [4:0] cursor_start,
  input wire [4:0] cursor_end,
  input wire cursor_disable,
  input wire [1:0] skew,
  input wire at_cursor,
  output reg cursor_on
);

  // =====================================================================
  // line window
  wire [4:0] end_eff = (cursor_end > cell_height) ? cell_height : cursor_end;
  // full 5-bit compare, no wrap into two parts
  wire line_hit = ~cursor_disable
                  & (cursor_start <= cursor_end)
                  & (row_scan >= cursor_start) & (row_scan <= end_eff);

  // =====================================================================
  // skew pipeline
  reg [1:0] skew_pipe_reg;
  wire raw = line_hit & at_cursor;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skew_pipe_reg <= 2'h0;
      cursor_on <= 1'b0;
    end else if (char_en) begin
      skew_pipe_reg <= {skew_pipe_reg[0], raw};
      case (skew)
        2'h2: cursor_on <= skew_pipe_reg[0];
        2'h3: cursor_on <= skew_pipe_reg[1];
        default: cursor_on <= raw;
      endcase
    end
  end

endmodule // cursor_shaper

/* hw/row_scan_counter.v */
/*
  row_scan_counter.v: character-row scan counter with preset, cell height
  rollover and scan doubling.
  assumes: line_end pulses once per scan line; vretrace_start once per frame.
*/
`include "crtc_regs.vh"

module row_scan_counter (
  input wire clk,
  input wire rst_n,
  input wire line_end,
  input wire vretrace_start,
  input wire [4:0] preset,
  input wire [4:0] cell_height,
  input wire scan_double,
  output reg [4:0] row_scan,
  output reg row_end
);

  reg half_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_scan <= 5'h00;
      half_reg <= 1'b0;
      row_end <= 1'b0;
    end else begin
      row_end <= 1'b0;
      if (vretrace_start) begin
        row_scan <= preset;
        half_reg <= 1'b0;
      end else if (line_end) begin
        // doubling only gates the advance; line timing is untouched
        if (scan_double && !half_reg) begin
          half_reg <= 1'b1;
        end else begin
          half_reg <= 1'b0;
          if (row_scan == cell_height || row_scan == `ROW_MAX) begin
            row_scan <= 5'h00;
            row_end <= 1'b1;
          end else begin
            row_scan <= row_scan + 5'h01;
          end
        end
      end
    end
  end

endmodule // row_scan_counter

/* hw/crtc_row_scan_cursor_start.v */
/*
  crtc_row_scan_cursor_start.v: apb slave holding preset row / byte pan,
  cell height / scan double, cursor shape, screen start address and the
  identification readback; drives row scan, cursor, pan and fetch address.
  assumes: timing events from an outer crtc, synchronous to clk (40 MHz).
*/
// The APB interface to the registers was decided locally.
// Function
// - preset loads row counter after vertical retrace
// - row counter clears at cell height
// - preset above height counts to 1fh
// - byte pan shifts 0 to 24 pixels
// - byte plus pixel pan up to 15/31
// - compat line compare zeroes pan until vsync; here only the byte pan is zeroed
// - scan double repeats lines, halves row advance
// - scan double leaves sync timing unchanged
// - cell height register carries two bit-9s
// - cell height field is lines minus one
// - cursor start gives first cursor line
// - start above end draws no cursor
// - height is end minus start plus one
// - cursor end gives last cursor line
// - end above height gives full block
// - skew delays cursor zero, one, two chars
// - write protect bit blocks cursor writes
// - start address is first fetch of screen
// - lower split screen fetches from zero
// - start high readable xored at 1f
`include "crtc_regs.vh"

module crtc_row_scan_cursor_start #(
  parameter [7:0] ID_XOR = 8'h5a // arbitrary identification value
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire char_en,
  input wire line_end,
  input wire vretrace_start,
  input wire vsync_start,
  input wire line_compare_hit,
  input wire word_mode,
  input wire dword_mode,
  input wire [3:0] horizontal_pixel_pan,
  input wire at_cursor,
  output reg [4:0] row_scan_out,
  output reg row_end_out,
  output reg scan_double_out,
  output reg [4:0] total_pan_out,
  output reg [15:0] fetch_start_out,
  output reg fetch_load_out,
  output reg line_compare_bit9,
  output reg vblank_start_bit9,
  output reg cursor_on_out
);

  // =====================================================================
  // reset release
  reg rst_meta_reg;
  reg rst_n;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // =====================================================================
  // registers
  reg [7:0] preset_row_and_byte_pan_reg;
  reg [7:0] cell_height_and_scan_double_reg;
  reg [7:0] cursor_start_line_reg;
  reg [7:0] cursor_end_line_skew_reg;
  reg [7:0] screen_start_address_high_reg;
  reg [7:0] screen_start_address_low_reg;
  reg [7:0] control_reg;
  reg pan_hold_reg;
  reg split_reg;

  function [7:0] index_of;
    input [9:0] a;
    begin
      index_of = a[9:2];
    end
  endfunction

  wire [7:0] idx = index_of(paddr);
  wire wp = control_reg[`CTRL_WP_BIT];
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;

  function is_mapped;
    input [7:0] i;
    begin
      case (i)
        `IDX_PRESET_ROW, `IDX_CELL_HEIGHT, `IDX_CURSOR_START, `IDX_CURSOR_END,
        `IDX_START_HIGH, `IDX_START_LOW, `IDX_START_ID, `IDX_CONTROL,
        `IDX_STATUS: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_row_and_byte_pan_reg <= `RST_REG8;
      cell_height_and_scan_double_reg <= `RST_REG8;
      cursor_start_line_reg <= `RST_REG8;
      cursor_end_line_skew_reg <= `RST_REG8;
      screen_start_address_high_reg <= `RST_REG8;
      screen_start_address_low_reg <= `RST_REG8;
      control_reg <= `RST_REG8;
    end else if (wr) begin
      case (idx)
        `IDX_PRESET_ROW: preset_row_and_byte_pan_reg <= {1'b0, pwdata[6:0]};
        `IDX_CELL_HEIGHT: cell_height_and_scan_double_reg <= pwdata[7:0];
        `IDX_CURSOR_START: begin
          if (!wp) begin
            cursor_start_line_reg <= {2'h0, pwdata[5:0]};
          end
        end
        `IDX_CURSOR_END: begin
          if (!wp) begin
            cursor_end_line_skew_reg <= {1'b0, pwdata[6:0]};
          end
        end
        `IDX_START_HIGH: screen_start_address_high_reg <= pwdata[7:0];
        `IDX_START_LOW: screen_start_address_low_reg <= pwdata[7:0];
        `IDX_CONTROL: control_reg <= {2'h0, pwdata[5:0]};
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // apb answer: no wait state, ready in the first access cycle
  wire [4:0] row_scan;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~is_mapped(idx);
      if (setup && !pwrite) begin
        case (idx)
          `IDX_PRESET_ROW: prdata <= {24'h000000, preset_row_and_byte_pan_reg};
          `IDX_CELL_HEIGHT: prdata <= {24'h000000, cell_height_and_scan_double_reg};
          `IDX_CURSOR_START: prdata <= {24'h000000, cursor_start_line_reg};
          `IDX_CURSOR_END: prdata <= {24'h000000, cursor_end_line_skew_reg};
          `IDX_START_HIGH: prdata <= {24'h000000, screen_start_address_high_reg};
          `IDX_START_LOW: prdata <= {24'h000000, screen_start_address_low_reg};
          `IDX_START_ID: prdata <= {24'h000000, screen_start_address_high_reg ^ ID_XOR};
          `IDX_CONTROL: prdata <= {24'h000000, control_reg};
          `IDX_STATUS: prdata <= {24'h000000, 1'b0, split_reg, pan_hold_reg, row_scan};
          default: prdata <= 32'h00000000;
        endcase
      end else if (!psel || setup) begin
        // a write setup also clears, so no stale read data rides on its answer
        prdata <= 32'h00000000;
      end
    end
  end

  // =====================================================================
  // row scan and cursor
  wire row_end;
  wire cursor_on;
  wire [4:0] cell_height = cell_height_and_scan_double_reg[`HEIGHT_MSB:`HEIGHT_LSB];

  // preset is taken at retrace; software should only change it then
  row_scan_counter u_row (
    .clk(clk),
    .rst_n(rst_n),
    .line_end(line_end),
    .vretrace_start(vretrace_start),
    .preset(preset_row_and_byte_pan_reg[`PRESET_MSB:`PRESET_LSB]),
    .cell_height(cell_height),
    .scan_double(cell_height_and_scan_double_reg[`SCAN_DOUBLE_BIT]),
    .row_scan(row_scan),
    .row_end(row_end)
  );

  cursor_shaper u_cursor (
    .clk(clk),
    .rst_n(rst_n),
    .char_en(char_en),
    .row_scan(row_scan),
    .cell_height(cell_height),
    .cursor_start(cursor_start_line_reg[4:0]),
    .cursor_end(cursor_end_line_skew_reg[4:0]),
    .cursor_disable(cursor_start_line_reg[`CURSOR_DISABLE_BIT]),
    .skew(cursor_end_line_skew_reg[`SKEW_MSB:`SKEW_LSB]),
    .at_cursor(at_cursor),
    .cursor_on(cursor_on)
  );

  // =====================================================================
  // panning and fetch start
  wire [1:0] byte_pan = preset_row_and_byte_pan_reg[`BYTE_PAN_MSB:`BYTE_PAN_LSB];
  wire [1:0] byte_pan_eff = pan_hold_reg ? 2'h0 : byte_pan;
  // byte shift in pixels: 0, 8, 16, 24
  wire [5:0] byte_px = {1'b0, byte_pan_eff, 3'h0};
  wire [5:0] pan_sum = byte_px + {2'h0, horizontal_pixel_pan};
  // cap by the addressing mode; byte mode caps at 31 like dword mode
  wire [4:0] pan_cap = dword_mode ? 5'h1f : (word_mode ? 5'h0f : 5'h1f);
  wire [4:0] pan_total = (pan_sum > {1'b0, pan_cap}) ? pan_cap : pan_sum[4:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pan_hold_reg <= 1'b0;
      split_reg <= 1'b0;
      row_scan_out <= 5'h00;
      row_end_out <= 1'b0;
      scan_double_out <= 1'b0;
      total_pan_out <= 5'h00;
      fetch_start_out <= 16'h0000;
      fetch_load_out <= 1'b0;
      line_compare_bit9 <= 1'b0;
      vblank_start_bit9 <= 1'b0;
      cursor_on_out <= 1'b0;
    end else begin
      // the vsync start wins over a same-cycle compare hit
      if (vsync_start) begin
        pan_hold_reg <= 1'b0;
      end else if (line_compare_hit && control_reg[`CTRL_PAN_COMPAT_BIT]) begin
        pan_hold_reg <= 1'b1;
      end
      // a same-cycle compare hit wins over the retrace clear
      if (line_compare_hit) begin
        split_reg <= 1'b1;
      end else if (vretrace_start) begin
        split_reg <= 1'b0;
      end
      fetch_load_out <= vretrace_start | line_compare_hit;
      if (line_compare_hit) begin
        fetch_start_out <= 16'h0000;
      end else if (vretrace_start) begin
        fetch_start_out <= {screen_start_address_high_reg, screen_start_address_low_reg};
      end
      row_scan_out <= row_scan;
      row_end_out <= row_end;
      scan_double_out <= cell_height_and_scan_double_reg[`SCAN_DOUBLE_BIT];
      total_pan_out <= pan_total;
      line_compare_bit9 <= cell_height_and_scan_double_reg[`LC_BIT9];
      vblank_start_bit9 <= cell_height_and_scan_double_reg[`VBS_BIT9];
      cursor_on_out <= cursor_on;
    end
  end

endmodule // crtc_row_scan_cursor_start

/* test/crt_timing_model.sv */
/*
  crt_timing_model.sv: raster event source standing in for the outer crtc.
  assumes: clk shared with the block under test; nrst active low.
*/
module crt_timing_model #(
  parameter int LINE = 8,
  parameter int LINES = 40
) (
  input wire logic clk,
  input wire logic nrst,
  output logic char_en,
  output logic line_end,
  output logic vretrace_start,
  output logic vsync_start,
  output logic line_compare_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc;
  int ln;
  // =====================================================================
  // raster counters
  // timing is fixed here, so scan doubling cannot move sync or retrace
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyc <= 0;
      ln <= 0;
    end else begin
      cyc <= (cyc == LINE - 1) ? 0 : cyc + 1;
      if (cyc == LINE - 1) ln <= (ln == LINES - 1) ? 0 : ln + 1;
    end
  end
  assign char_en = nrst;
  assign line_end = (cyc == LINE - 1);
  // events sit mid-line so they never meet a line end
  assign vretrace_start = (cyc == 2) && (ln == 0);
  assign vsync_start = (cyc == 2) && (ln == LINES - 4);
  assign line_compare_hit = (cyc == 2) && (ln == LINES / 2);
endmodule // crt_timing_model

/* test/crtc_row_scan_cursor_start_assertions.sv */
/*
  crtc_row_scan_cursor_start_assertions.sv: checker of port relations.
  assumes: bound to the block top; one clock domain, nrst active low.
*/
module crtc_rsc_checker (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire line_end,
  input wire vretrace_start,
  input wire line_compare_hit,
  input wire word_mode,
  input wire [4:0] row_scan_out,
  input wire row_end_out,
  input wire [4:0] total_pan_out,
  input wire [15:0] fetch_start_out,
  input wire fetch_load_out,
  input wire cursor_on_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // =====================================================================
  // register bus
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("setup not answered next cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  a_idle_data: assert property (!psel |=> prdata == 32'h0)
    else $error("read data not cleared when idle");
  // =====================================================================
  // display side
  a_word_cap: assert property (word_mode && $past(word_mode) |-> total_pan_out <= 5'd15)
    else $error("word mode pan above 15");
  a_split_zero: assert property (line_compare_hit |=> fetch_load_out && fetch_start_out == 16'h0)
    else $error("lower screen not fetched from zero");
  a_retrace_load: assert property (vretrace_start |=> fetch_load_out)
    else $error("start address not loaded after retrace");
  a_load_cause: assert property (fetch_load_out |-> $past(vretrace_start) || $past(line_compare_hit))
    else $error("fetch load without cause");
  a_row_hold: assert property ((!line_end && !vretrace_start) [*2] |=> $stable(row_scan_out))
    else $error("row scan moved without a line end");
  a_end_at_zero: assert property (row_end_out |-> row_scan_out == 5'h00)
    else $error("row end pulse while row scan not zero");
  c_split: cover property (line_compare_hit ##1 fetch_load_out);
  c_err: cover property (pslverr);
  c_cursor: cover property ($rose(cursor_on_out));
  c_row_end: cover property (row_end_out);
endmodule // crtc_rsc_checker

bind crtc_row_scan_cursor_start crtc_rsc_checker u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_end(line_end), .vretrace_start(vretrace_start),
  .line_compare_hit(line_compare_hit), .word_mode(word_mode), .row_scan_out(row_scan_out),
  .row_end_out(row_end_out), .total_pan_out(total_pan_out), .fetch_start_out(fetch_start_out),
  .fetch_load_out(fetch_load_out), .cursor_on_out(cursor_on_out));

/* test/crtc_row_scan_cursor_start_test.sv */
/*
  crtc_row_scan_cursor_start_test.sv: self-checking bench, apb master.
  assumes: crt_timing_model supplies raster events; clk 40 MHz.
*/
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module crtc_row_scan_cursor_start_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3c; // arbitrary identification value
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, word_mode = 0, dword_mode = 0, at_cursor = 0;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] hp = 0;
  logic pready, pslverr, ce, le, vr, vs, lc, sd, fl, lb9, vb9, con;
  logic [4:0] rs, tp;
  logic [15:0] fs;
  logic [3:0] ev;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  assign ev = {lc, vs, vr, le};
  crt_timing_model u_tm (.clk(clk), .nrst(nrst), .char_en(ce), .line_end(le), .vretrace_start(vr),
    .vsync_start(vs), .line_compare_hit(lc));
  crtc_row_scan_cursor_start #(.ID_XOR(ID)) u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .char_en(ce), .line_end(le), .vretrace_start(vr), .vsync_start(vs), .line_compare_hit(lc),
    .word_mode(word_mode), .dword_mode(dword_mode), .horizontal_pixel_pan(hp), .at_cursor(at_cursor),
    .row_scan_out(rs), .row_end_out(), .scan_double_out(sd), .total_pan_out(tp), .fetch_start_out(fs),
    .fetch_load_out(fl), .line_compare_bit9(lb9), .vblank_start_bit9(vb9), .cursor_on_out(con));
  initial forever #12.5 clk = ~clk;
  // =====================================================================
  // helpers
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, i, 8'h00, r, e);
    `CK("prdata", {24'h0, x}, r)
  endtask
  // waits for a raster event: 0 line end, 1 retrace, 2 vsync, 3 compare
  task automatic w(input int s);
    do @(negedge clk); while (ev[s] !== 1'b1);
  endtask
  function automatic logic [4:0] nxt(input logic [4:0] r, input logic [4:0] h);
    return (r == h || r == 5'h1f) ? 5'h00 : r + 5'h01;
  endfunction
  // =====================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] ix[6] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] wv[6] = '{8'h80, 8'h5f, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] xv[6] = '{8'h00, 8'h5f, 8'h3f, 8'h7f, 8'hff, 8'hff};
    logic [31:0] r;
    logic e;
    foreach (ix[k]) rd(ix[k], 8'h00);
    foreach (ix[k]) wr(ix[k], wv[k]);
    foreach (ix[k]) rd(ix[k], xv[k]);
    `CK("line_compare_bit9", 1'b1, lb9)
    `CK("vblank_start_bit9", 1'b0, vb9)
    apb(1'b1, 8'h30, 8'h55, r, e);
    `CK("pslverr", 1'b1, e)
    apb(1'b0, 8'h30, 8'h00, r, e);
    `CK("pslverr", 1'b1, e)
    `CK("prdata", 32'h0, r)
    wr(8'h20, 8'h10);
    wr(8'h0a, 8'h05);
    wr(8'h0b, 8'h01);
    rd(8'h0a, 8'h3f);
    rd(8'h0b, 8'h7f);
    wr(8'h20, 8'h00);
    wr(8'h0a, 8'h05);
    rd(8'h0a, 8'h05);
  endtask
  task automatic t_fetch;
    logic [31:0] r;
    logic e;
    wr(8'h0c, 8'h12);
    wr(8'h0d, 8'hab);
    rd(8'h1f, 8'h12 ^ ID);
    w(1);
    @(negedge clk);
    `CK("fetch_load_out", 1'b1, fl)
    `CK("fetch_start_out", 16'h12ab, fs)
    w(3);
    @(negedge clk);
    `CK("fetch_start_out", 16'h0000, fs)
    apb(1'b0, 8'h21, 8'h00, r, e);
    `CK("status split", 2'h2, r[6:5])
  endtask
  task automatic t_pan;
    wr(8'h20, 8'h00);
    @(posedge clk);
    dword_mode <= 1'b1;
    hp <= 4'h3;
    for (int b = 0; b < 4; b++) begin
      wr(8'h08, {1'b0, b[1:0], 5'h00});
      repeat (3) @(negedge clk);
      `CK("total_pan_out", {b[1:0], 3'h3}, tp)
    end
    @(posedge clk);
    word_mode <= 1'b1;
    dword_mode <= 1'b0;
    hp <= 4'h7;
    repeat (3) @(negedge clk);
    `CK("total_pan_out", 5'd15, tp)
    @(posedge clk);
    word_mode <= 1'b0;
    dword_mode <= 1'b1;
    hp <= 4'hf;
    repeat (3) @(negedge clk);
    `CK("total_pan_out", 5'd31, tp)
    wr(8'h20, 8'h20);
    w(3);
    repeat (3) @(negedge clk);
    `CK("total_pan_out", 5'd15, tp)
    w(2);
    repeat (3) @(negedge clk);
    `CK("total_pan_out", 5'd31, tp)
  endtask
  task automatic t_rows(input logic [4:0] p, input logic [4:0] h, input logic d);
    logic [4:0] r;
    logic ph;
    w(2);
    wr(8'h08, {3'h0, p});
    wr(8'h09, {d, 2'h0, h});
    w(1);
    r = p;
    ph = 1'b0;
    repeat (30) begin
      w(0);
      `CK("row_scan_out", r, rs)
      if (!d || ph) r = nxt(r, h);
      ph = ph ^ d;
    end
    `CK("scan_double_out", d, sd)
  endtask
  task automatic t_cur(input logic [4:0] s, input logic [4:0] e, input logic dis);
    logic [4:0] r;
    logic x;
    w(2);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h07);
    wr(8'h0a, {2'h0, dis, s});
    wr(8'h0b, {3'h0, e});
    w(1);
    r = 5'h00;
    repeat (16) begin
      w(0);
      x = !dis && s <= e && r >= s && r <= ((e > 5'h07) ? 5'h07 : e);
      `CK("cursor_on_out", x, con)
      r = nxt(r, 5'h07);
    end
  endtask
  task automatic t_skew;
    int d[4];
    wr(8'h0a, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h0b, {1'b0, k[1:0], 5'h1f});
      @(posedge clk);
      at_cursor <= 1'b0;
      repeat (6) @(posedge clk);
      at_cursor <= 1'b1;
      @(posedge clk);
      at_cursor <= 1'b0;
      d[k] = 0;
      do begin
        @(negedge clk);
        d[k]++;
      end while (con !== 1'b1 && d[k] < 20);
      @(negedge clk);
      `CK("cursor width", 1'b0, con)
    end
    `CK("skew 1", d[0], d[1])
    `CK("skew 2", d[0] + 1, d[2])
    `CK("skew 3", d[0] + 2, d[3])
  endtask
  // =====================================================================
  // run control
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang ends the run well past the longest expected sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    at_cursor <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_fetch;
    t_pan;
    t_rows(5'd2, 5'd3, 1'b0);
    t_rows(5'd5, 5'd3, 1'b0);
    t_rows(5'd1, 5'd2, 1'b1);
    t_cur(5'd2, 5'd4, 1'b0);
    t_cur(5'd4, 5'd4, 1'b0);
    t_cur(5'd5, 5'd3, 1'b0);
    t_cur(5'd2, 5'd20, 1'b0);
    t_cur(5'd2, 5'd4, 1'b1);
    t_skew;
    test_done;
  end
endmodule // crtc_row_scan_cursor_start_test
